/* core/ifb_interrupt_flag_enable_bank.sv */
// Functional notes
// - Pin-one edge bits 3:2 decode off, rising, falling, both.
// - Pin-zero edge bits 1:0 use the same four-way decode.
// - Third interrupt line is fed by the CAN interrupt output, not a pin.
// - Unimplemented bits of control a and multifunction registers read zero.
// - Control a bit 0 is global enable; zero blocks every source.
// - Control a holds adc, pin-one, pin-zero flags 6:4 and enables 3:1.
// - Control b holds time-base one, zero, eeprom flags 7:5, enables 3:1.
// - Control c holds CAN flag 7, group flags 6:4, CAN enable 3, groups 2:0.
// - Multifunction a holds compact timer A/P flags 5:4, enables 1:0.
// - Multifunction b and c repeat that layout for standard timers.
// - Each source has RW flag and enable; events set flags regardless of enable.
// - Service only when flag, own enable and global enable are all set.
// - Service entry clears the global enable; later events still latch.
// - Service of pin or CAN-line source clears its flag automatically.
// - CAN line detects the edge chosen by edge bits 5:4, whatever the output polarity.
`timescale 1ns/1ps
module ifb_interrupt_flag_enable_bank
  import ifb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] sfrSel,
  input wire logic sfrWr,
  input wire logic [7:0] sfrWdata,
  input wire ifb_event_t events,
  input wire logic stackFull,
  output logic [7:0] sfrRdata,
  output logic irqTake,
  output logic [3:0] irqVector,
  output logic canLineLevel
);

  ifb_state_t s_q;
  ifb_state_t s_d;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Both edges compare the previous sample with the current one, so a pin is read once per clock
  function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    case (sel)
      EDGE_RISE: edgeHit = rise;
      EDGE_FALL: edgeHit = fall;
      EDGE_BOTH: edgeHit = rise || fall;
      default: edgeHit = 1'b0;
    endcase
  endfunction : edgeHit

  // Only implemented bits of control a and multifunction are stored; edge and control b store all eight
  function automatic logic [7:0] wrMask(input logic [2:0] idx);
    case (idx)
      IDX_PRIMARY_CTRL_A: wrMask = MASK_CTRL_A;
      IDX_MULTIFUNC_CTRL_A, IDX_MULTIFUNC_CTRL_B, IDX_MULTIFUNC_CTRL_C: wrMask = MASK_MULTIFUNC;
      default: wrMask = MASK_FULL;
    endcase
  endfunction : wrMask

  // Index 7 is unmapped: writes are dropped and reads return zero
  function automatic logic isMapped(input logic [2:0] idx);
    isMapped = int'(idx) < NUM_REGS;
  endfunction : isMapped

  // Multifunction registers sit at consecutive indices
  function automatic int groupReg(input int g);
    groupReg = int'(IDX_MULTIFUNC_CTRL_A) + g;
  endfunction : groupReg

  // Request of one source: its flag and its own enable, global enable aside
  function automatic logic srcRequest(input logic [NUM_REGS-1:0][7:0] regs, input int i);
    srcRequest = regs[SRC_REG[i]][SRC_FLAG[i]] && regs[SRC_REG[i]][SRC_EN[i]];
  endfunction : srcRequest

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Scratch values of the combinational pass
  logic [NUM_SRC-1:0] pending;
  logic found;
  logic [3:0] winner;
  logic [2:0] curLevel;
  logic [7:0] mfr;
  logic grpHit;

  always_comb begin
    s_d = s_q;
    found = 1'b0;
    winner = 4'h0;
    mfr = 8'h00;
    grpHit = 1'b0;
    curLevel = {events.canIrqOutput, events.pinOne, events.pinZero};
    s_d.prevLevel = curLevel;
    s_d.service.take = 1'b0;

    // --------------------------------------------------------
    // Arbitration
    // --------------------------------------------------------
    // Arbitration uses registered flags; index 0 is highest priority
    for (int i = 0; i < NUM_SRC; i++) begin
      pending[i] = srcRequest(s_q.regs, i);
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        winner = 4'(i);
      end
    end

    // --------------------------------------------------------
    // Register writes
    // --------------------------------------------------------
    // Software write first
    // Masked bits are dropped here so they always read back as zero
    if (sfrWr && isMapped(sfrSel)) begin
      s_d.regs[sfrSel] = sfrWdata & wrMask(sfrSel);
    end

    // --------------------------------------------------------
    // Service entry
    // --------------------------------------------------------
    // Service entry overrides a same-cycle software write of the enable
    // A full stack holds the request off; the flag stays recorded meanwhile
    if (found && s_q.regs[IDX_PRIMARY_CTRL_A][POS_GLOBAL_IRQ_ENABLE] && !stackFull) begin
      s_d.service.take = 1'b1;
      s_d.service.vector = winner;
      s_d.regs[IDX_PRIMARY_CTRL_A][POS_GLOBAL_IRQ_ENABLE] = 1'b0;
      if (SRC_AUTOCLR[winner]) begin
        s_d.regs[SRC_REG[winner]][SRC_FLAG[winner]] = 1'b0;
      end
    end

    // --------------------------------------------------------
    // Event capture
    // --------------------------------------------------------
    // Events last, so a set wins over any clear in the same cycle
    if (edgeHit(s_q.regs[IDX_EDGE_SELECT][POS_PIN_ZERO_EDGE_SEL +: 2], s_q.prevLevel[0], curLevel[0])) begin
      s_d.regs[IDX_PRIMARY_CTRL_A][POS_PIN_ZERO_REQ_FLAG] = 1'b1;
    end
    if (edgeHit(s_q.regs[IDX_EDGE_SELECT][POS_PIN_ONE_EDGE_SEL +: 2], s_q.prevLevel[1], curLevel[1])) begin
      s_d.regs[IDX_PRIMARY_CTRL_A][POS_PIN_ONE_REQ_FLAG] = 1'b1;
    end
    if (edgeHit(s_q.regs[IDX_EDGE_SELECT][POS_CAN_LINE_EDGE_SEL +: 2], s_q.prevLevel[2], curLevel[2])) begin
      s_d.regs[IDX_PRIMARY_CTRL_C][POS_CAN_LINE_REQ_FLAG] = 1'b1;
    end
    if (events.adcDone) begin
      s_d.regs[IDX_PRIMARY_CTRL_A][POS_ADC_REQ_FLAG] = 1'b1;
    end
    if (events.eepromDone) begin
      s_d.regs[IDX_PRIMARY_CTRL_B][POS_EEPROM_REQ_FLAG] = 1'b1;
    end
    if (events.timebaseZero) begin
      s_d.regs[IDX_PRIMARY_CTRL_B][POS_TIMEBASE_ZERO_REQ_FLAG] = 1'b1;
    end
    if (events.timebaseOne) begin
      s_d.regs[IDX_PRIMARY_CTRL_B][POS_TIMEBASE_ONE_REQ_FLAG] = 1'b1;
    end

    // --------------------------------------------------------
    // Compare groups
    // --------------------------------------------------------
    // Compare flags are never cleared here; the group flag carries the service
    // A pulse with its enable low sets only the compare flag
    for (int g = 0; g < 3; g++) begin
      mfr = s_d.regs[groupReg(g)];
      grpHit = 1'b0;
      if (events.cmppMatch[g]) begin
        mfr[POS_CMPP_FLAG] = 1'b1;
        grpHit = grpHit || mfr[POS_CMPP_EN];
      end
      if (events.cmpaMatch[g]) begin
        mfr[POS_CMPA_FLAG] = 1'b1;
        grpHit = grpHit || mfr[POS_CMPA_EN];
      end
      s_d.regs[groupReg(g)] = mfr;
      if (grpHit) begin
        s_d.regs[IDX_PRIMARY_CTRL_C][POS_GROUP_REQ_FLAG + g] = 1'b1;
      end
    end

    // --------------------------------------------------------
    // Read path
    // --------------------------------------------------------
    // Read data reflects the stored value one cycle after selection
    s_d.readData = isMapped(sfrSel) ? s_q.regs[sfrSel] : 8'h00;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      // Clears every flag and enable, so nothing is pending after reset
      for (int r = 0; r < NUM_REGS; r++) begin
        s_q.regs[r] <= REG_RESET;
      end
      // Level history starts low: a line already high at release reads as a rising edge
      s_q.prevLevel <= 3'h0;
      s_q.service.take <= 1'b0;
      s_q.service.vector <= 4'h0;
      s_q.readData <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output is a plain copy of a state flip-flop
  assign sfrRdata = s_q.readData;
  assign irqTake = s_q.service.take;
  assign irqVector = s_q.service.vector;
  assign canLineLevel = s_q.prevLevel[2];

endmodule : ifb_interrupt_flag_enable_bank

/* core/ifb_pkg.sv */
package ifb_pkg;

  // ------------------------------------------------------------
  // Register indices in special-purpose data memory
  // ------------------------------------------------------------
  localparam logic [2:0] IDX_EDGE_SELECT = 3'h0;
  localparam logic [2:0] IDX_PRIMARY_CTRL_A = 3'h1;
  localparam logic [2:0] IDX_PRIMARY_CTRL_B = 3'h2;
  localparam logic [2:0] IDX_PRIMARY_CTRL_C = 3'h3;
  localparam logic [2:0] IDX_MULTIFUNC_CTRL_A = 3'h4;
  localparam logic [2:0] IDX_MULTIFUNC_CTRL_B = 3'h5;
  localparam logic [2:0] IDX_MULTIFUNC_CTRL_C = 3'h6;
  localparam int NUM_REGS = 7;

  // ------------------------------------------------------------
  // Implemented bits and reset value
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_CTRL_A = 8'h7f;
  localparam logic [7:0] MASK_MULTIFUNC = 8'h33;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POS_PIN_ZERO_EDGE_SEL = 0;
  localparam int POS_PIN_ONE_EDGE_SEL = 2;
  localparam int POS_CAN_LINE_EDGE_SEL = 4;
  localparam int POS_GLOBAL_IRQ_ENABLE = 0;
  localparam int POS_PIN_ZERO_REQ_FLAG = 4;
  localparam int POS_PIN_ONE_REQ_FLAG = 5;
  localparam int POS_ADC_REQ_FLAG = 6;
  localparam int POS_EEPROM_REQ_FLAG = 5;
  localparam int POS_TIMEBASE_ZERO_REQ_FLAG = 6;
  localparam int POS_TIMEBASE_ONE_REQ_FLAG = 7;
  localparam int POS_GROUP_REQ_FLAG = 4;
  localparam int POS_CAN_LINE_REQ_FLAG = 7;
  localparam int POS_CMPP_EN = 0;
  localparam int POS_CMPA_EN = 1;
  localparam int POS_CMPP_FLAG = 4;
  localparam int POS_CMPA_FLAG = 5;

  // Edge selector codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ------------------------------------------------------------
  // Sources in priority order, index 0 highest
  // ------------------------------------------------------------
  localparam int NUM_SRC = 10;
  localparam logic [2:0] SRC_REG [NUM_SRC] = '{
    3'h1, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h1, 3'h2, 3'h2, 3'h2};
  localparam logic [2:0] SRC_FLAG [NUM_SRC] = '{
    3'h4, 3'h5, 3'h7, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h7, 3'h5};
  localparam logic [2:0] SRC_EN [NUM_SRC] = '{
    3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h1};
  // Sources whose flag hardware clears on service (pins, CAN line, groups)
  localparam logic [NUM_SRC-1:0] SRC_AUTOCLR = 10'h03f;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic pinZero;
    logic pinOne;
    logic canIrqOutput;
    logic adcDone;
    logic eepromDone;
    logic timebaseZero;
    logic timebaseOne;
    logic [2:0] cmpaMatch;
    logic [2:0] cmppMatch;
  } ifb_event_t;

  typedef struct packed {
    logic take;
    logic [3:0] vector;
  } ifb_take_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [2:0] prevLevel;
    ifb_take_t service;
    logic [7:0] readData;
  } ifb_state_t;

endpackage : ifb_pkg

/* verif/ifb_checker.sv */
`timescale 1ns/1ps
module ifb_checker
  import ifb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] sfrSel,
  input wire logic sfrWr,
  input wire logic [7:0] sfrWdata,
  input wire ifb_event_t events,
  input wire logic stackFull,
  input wire logic [7:0] sfrRdata,
  input wire logic irqTake,
  input wire logic [3:0] irqVector,
  input wire logic canLineLevel
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_unmapped_reads_zero: assert property ($past(resetn) && $past(sfrSel) == 3'h7 |-> sfrRdata == 8'h00)
    else $error("unmapped index read nonzero");
  a_ctrl_a_top: assert property ($past(resetn) && $past(sfrSel) == IDX_PRIMARY_CTRL_A |-> !sfrRdata[7])
    else $error("control a bit 7 read nonzero");
  a_multifunc_gaps_zero: assert property ($past(resetn) && $past(sfrSel) >= IDX_MULTIFUNC_CTRL_A &&
    $past(sfrSel) <= IDX_MULTIFUNC_CTRL_C |-> (sfrRdata & ~MASK_MULTIFUNC) == 8'h00)
    else $error("multifunction gap bits read nonzero");
  a_take_single_pulse: assert property (irqTake |=> !irqTake)
    else $error("service taken twice without global enable");
  a_stack_blocks_take: assert property ($past(resetn) && $past(stackFull) |-> !irqTake)
    else $error("service taken while stack full");
  a_global_off_blocks: assert property (sfrWr && sfrSel == IDX_PRIMARY_CTRL_A && !sfrWdata[0] |=> ##1 !irqTake)
    else $error("service taken with global enable cleared");
  a_can_line_copy: assert property ($past(resetn) |-> canLineLevel == $past(events.canIrqOutput))
    else $error("CAN line level not following CAN output");
  a_vector_holds: assert property ($past(resetn) && !irqTake |-> $stable(irqVector))
    else $error("vector changed without a take");
  c_take_pin: cover property (irqTake && irqVector == 4'h0);
  c_take_adc: cover property (irqTake && irqVector == 4'h6);
  c_stack_hold: cover property (stackFull && !irqTake);
endmodule : ifb_checker

bind ifb_interrupt_flag_enable_bank ifb_checker ifb_checker_i (.clk(clk), .resetn(resetn), .sfrSel(sfrSel),
  .sfrWr(sfrWr), .sfrWdata(sfrWdata), .events(events), .stackFull(stackFull), .sfrRdata(sfrRdata),
  .irqTake(irqTake), .irqVector(irqVector), .canLineLevel(canLineLevel));

/* verif/ifb_cpu_model.sv */
`timescale 1ns/1ps
module ifb_cpu_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic irqTake,
  input wire logic [3:0] irqVector,
  input wire logic holdStack,
  output logic stackFull,
  output int takes,
  output logic [3:0] lastVec
);
  // ----------------------------------------
  // Vector capture and stack depth
  // ----------------------------------------
  // Stack stays full as long as the bench holds it, like nested calls never returning
  assign stackFull = holdStack;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      takes <= 0;
      lastVec <= 4'h0;
    end else if (irqTake) begin
      takes <= takes + 1;
      lastVec <= irqVector;
    end
  end
endmodule : ifb_cpu_model

/* verif/ifb_interrupt_flag_enable_bank_bench.sv */
`timescale 1ns/1ps
module ifb_interrupt_flag_enable_bank_bench;
  import ifb_pkg::*;
  logic clk = 0, resetn = 0, sfrWr = 0, holdStack = 0, stackFull, irqTake, canLineLevel;
  logic [2:0] sfrSel = 3'h0;
  logic [7:0] sfrWdata = 8'h00, sfrRdata;
  logic [3:0] irqVector, lastVec;
  ifb_event_t ev = '0;
  int takes, mismatches = 0, compares = 0;
  // Reserved bits of edge and control b kept zero, CAN edge code 10
  logic [7:0] wv [8] = '{8'h2f, 8'hfe, 8'hee, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] xv [8] = '{8'h2f, 8'h7e, 8'hee, 8'hff, 8'h33, 8'h33, 8'h33, 8'h00};
  initial forever #10 clk = ~clk;
  ifb_interrupt_flag_enable_bank ifb_interrupt_flag_enable_bank_i (.clk(clk), .resetn(resetn), .sfrSel(sfrSel),
    .sfrWr(sfrWr), .sfrWdata(sfrWdata), .events(ev), .stackFull(stackFull), .sfrRdata(sfrRdata),
    .irqTake(irqTake), .irqVector(irqVector), .canLineLevel(canLineLevel));
  ifb_cpu_model ifb_cpu_model_i (.clk(clk), .resetn(resetn), .irqTake(irqTake), .irqVector(irqVector),
    .holdStack(holdStack), .stackFull(stackFull), .takes(takes), .lastVec(lastVec));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task check(string n, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task wr(logic [2:0] s, logic [7:0] d);
    @(negedge clk);
    sfrSel = s;
    sfrWr = 1;
    sfrWdata = d;
    @(negedge clk);
    sfrWr = 0;
  endtask : wr
  task rd(logic [2:0] s, logic [7:0] e, string n);
    @(negedge clk);
    sfrSel = s;
    @(negedge clk);
    check(n, sfrRdata, e);
  endtask : rd
  task lev(int s, logic v);
    @(negedge clk);
    if (s == 0) ev.pinZero = v;
    else if (s == 1) ev.pinOne = v;
    else ev.canIrqOutput = v;
    repeat (2) @(negedge clk);
  endtask : lev
  // Bounded wait for the next service entry
  task await(logic [3:0] v);
    int t0;
    t0 = takes;
    for (int i = 0; i < 10 && takes == t0; i++) @(negedge clk);
    if (takes == t0) begin
      mismatches++;
      stop_test();
    end else begin
      check("vector", {4'h0, lastVec}, {4'h0, v});
    end
  endtask : await
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    for (int r = 0; r < 8; r++) rd(3'(r), 8'h00, "reset");
    for (int r = 0; r < 8; r++) begin
      wr(3'(r), wv[r]);
      rd(3'(r), xv[r], "mask");
      wr(3'(r), 8'h00);
    end
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) begin
        automatic int b = (s == 2) ? 7 : 4 + s;
        automatic logic [2:0] fr = (s == 2) ? 3'h3 : 3'h1;
        if (s == 2 && (c == 0 || c == 3)) continue;
        wr(3'h0, 8'(c << (2 * s)));
        lev(s, 1);
        if (s == 2) check("can level", {7'h00, canLineLevel}, 8'h01);
        rd(fr, c[0] ? 8'h01 << b : 8'h00, "rise");
        wr(fr, 8'h00);
        lev(s, 0);
        if (s == 2) check("can level", {7'h00, canLineLevel}, 8'h00);
        rd(fr, c[1] ? 8'h01 << b : 8'h00, "fall");
        wr(fr, 8'h00);
      end
    end
    @(negedge clk);
    {ev.adcDone, ev.eepromDone, ev.timebaseZero, ev.timebaseOne, ev.cmpaMatch, ev.cmppMatch} = 10'h3ff;
    @(negedge clk);
    {ev.adcDone, ev.eepromDone, ev.timebaseZero, ev.timebaseOne, ev.cmpaMatch, ev.cmppMatch} = 10'h000;
    rd(3'h1, 8'h40, "adc");
    rd(3'h2, 8'he0, "ctrl_b");
    rd(3'h3, 8'h00, "groups");
    for (int t = 4; t < 7; t++) rd(3'(t), 8'h30, "compare");
    for (int t = 1; t < 7; t++) wr(3'(t), 8'h00);
    for (int t = 0; t < 3; t++) begin
      wr(3'(t + 4), 8'h03);
      @(negedge clk);
      ev.cmpaMatch = 3'(1 << t);
      @(negedge clk);
      ev.cmpaMatch = 3'h0;
      rd(3'(t + 4), 8'h23, "cmpa");
      rd(3'h3, 8'(1 << (t + 4)), "group");
      wr(3'(t + 4), 8'h00);
      wr(3'h3, 8'h00);
      wr(3'(t + 4), 8'h01);
      @(negedge clk);
      ev.cmppMatch = 3'(1 << t);
      @(negedge clk);
      ev.cmppMatch = 3'h0;
      rd(3'(t + 4), 8'h11, "cmpp");
      rd(3'h3, 8'(1 << (t + 4)), "group p");
      wr(3'(t + 4), 8'h00);
      wr(3'h3, 8'h00);
    end
    wr(3'h1, 8'h12);
    rd(3'h1, 8'h12, "held");
    holdStack = 1;
    wr(3'h1, 8'h13);
    repeat (4) @(negedge clk);
    check("takes", 8'(takes), 8'h00);
    holdStack = 0;
    await(4'h0);
    rd(3'h1, 8'h02, "pin0 cleared");
    wr(3'h2, 8'h44);
    wr(3'h1, 8'h6d);
    await(4'h1);
    rd(3'h1, 8'h4c, "pin1 cleared");
    wr(3'h1, 8'h4d);
    await(4'h6);
    rd(3'h1, 8'h4c, "adc kept");
    wr(3'h1, 8'h01);
    await(4'h7);
    rd(3'h2, 8'h44, "timebase kept");
    stop_test();
  end
endmodule : ifb_interrupt_flag_enable_bank_bench
